// [include/kli_pkg.sv]
// constants shared by the keypad level interrupt unit
package kli_pkg;
    // ***********************************************************
    // bus and port sizes
    // ***********************************************************
    localparam int KLI_DATA_W = 32;
    localparam int KLI_ADDR_W = 12;
    localparam int KLI_LINES = 8;
    localparam int KLI_IDX_W = 10;
    localparam int KLI_IRQ_W = 2;

    // ***********************************************************
    // register indices (byte address is four times the index)
    // ***********************************************************
    localparam logic [KLI_IDX_W-1:0] KLI_IDX_LEVEL = 10'h09C;
    localparam logic [KLI_IDX_W-1:0] KLI_IDX_ENABLE = 10'h09D;
    localparam logic [KLI_IDX_W-1:0] KLI_IDX_FLAGS = 10'h09E;
    localparam logic [KLI_IDX_W-1:0] KLI_IDX_GLOBAL = 10'h09F;
    localparam logic [KLI_IDX_W-1:0] KLI_IDX_IRQ_STATUS = 10'h0A0;
    localparam logic [KLI_IDX_W-1:0] KLI_IDX_IRQ_CLEAR = 10'h0A1;
    localparam logic [KLI_IDX_W-1:0] KLI_IDX_IRQ_ENABLE = 10'h0A2;

    // ***********************************************************
    // reset values and field positions
    // ***********************************************************
    localparam logic [KLI_LINES-1:0] KLI_LINE_RESET = 8'h00;
    localparam logic [KLI_LINES-1:0] KLI_LINE_ONES = 8'hFF;
    localparam logic [KLI_IRQ_W-1:0] KLI_IRQ_RESET = 2'h0;
    localparam int KLI_GLOBAL_BIT = 0;
    localparam int KLI_IRQ_FLAG_SET = 0;
    localparam int KLI_IRQ_REQ_RISE = 1;

    // ***********************************************************
    // axi4-lite responses
    // ***********************************************************
    localparam logic [1:0] KLI_RESP_OKAY = 2'h0;
    localparam logic [1:0] KLI_RESP_SLVERR = 2'h2;
endpackage : kli_pkg

// [include/kli_sync_if.sv]
// carrier between the top and the port line synchroniser
`timescale 1ns/1ns
interface kli_sync_if;
    logic [kli_pkg::KLI_LINES-1:0] raw;
    logic [kli_pkg::KLI_LINES-1:0] synced;
    modport top (output raw, input synced);
    modport sync (input raw, output synced);
endinterface : kli_sync_if

// [rtl/kli_keypad_top.sv]
// keypad level interrupt unit with axi4-lite register slave
// How it works
// - flag n sets whenever port line n sits at its selected level
// - a set flag raises a keyboard request only while its enable bit is one
// - hardware never clears flags; software writes zero to clear each
// - enable zero keeps a line out of key_req and wake_req; its flag still sets and still raises the flag-set irq status bit
// - level bit zero detects low, one detects high
// - flags, enables and level selects all reset to zero
// - all eight line requests merge into one keyboard request
// - a global keyboard enable gates the merged request
// - an enabled active line raises a wake request for idle and power-down
`timescale 1ns/1ns
module kli_keypad_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [kli_pkg::KLI_LINES-1:0] port_lines,
    output logic key_req,
    output logic wake_req,
    output logic irq,
    input wire logic [kli_pkg::KLI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [kli_pkg::KLI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [kli_pkg::KLI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [kli_pkg::KLI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int LN = kli_pkg::KLI_LINES;
    localparam int IW = kli_pkg::KLI_IRQ_W;

    // ***********************************************************
    // decode helpers
    // ***********************************************************
    function automatic logic [kli_pkg::KLI_IDX_W-1:0] reg_index(
        input logic [kli_pkg::KLI_ADDR_W-1:0] addr);
        reg_index = addr[kli_pkg::KLI_ADDR_W-1:2];
    endfunction : reg_index

    function automatic logic idx_mapped(input logic [kli_pkg::KLI_IDX_W-1:0] idx);
        idx_mapped = (idx >= kli_pkg::KLI_IDX_LEVEL) && (idx <= kli_pkg::KLI_IDX_IRQ_ENABLE);
    endfunction : idx_mapped

    // ***********************************************************
    // state
    // ***********************************************************
    logic [LN-1:0] line_level_select_reg;
    logic [LN-1:0] line_interrupt_enable_reg;
    logic [LN-1:0] line_event_flags_reg;
    logic [LN-1:0] line_event_flags_next;
    logic keypad_global_enable_reg;
    logic key_req_reg;
    logic wake_req_reg;
    logic [IW-1:0] irq_status_reg;
    logic [IW-1:0] irq_status_next;
    logic [IW-1:0] irq_enable_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [kli_pkg::KLI_ADDR_W-1:0] awaddr_reg;
    logic [kli_pkg::KLI_DATA_W-1:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [kli_pkg::KLI_DATA_W-1:0] rdata_reg;

    logic [LN-1:0] line_sync;
    logic [LN-1:0] line_match;
    logic [LN-1:0] active_lines;
    logic any_active;
    logic do_write;
    logic lane0;
    logic [kli_pkg::KLI_IDX_W-1:0] wr_idx;
    logic [kli_pkg::KLI_IDX_W-1:0] rd_idx;
    logic wr_flags;
    logic wr_clear;
    logic [LN-1:0] flag_keep;
    logic [IW-1:0] irq_events;
    logic [kli_pkg::KLI_DATA_W-1:0] rd_value;

    // ***********************************************************
    // port line synchroniser
    // ***********************************************************
    kli_sync_if sync_bus ();
    assign sync_bus.raw = port_lines;
    assign line_sync = sync_bus.synced;

    kli_line_sync u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .lines(sync_bus)
    );

    // ***********************************************************
    // level detection and flags
    // ***********************************************************
    // a line held at its selected level keeps its flag set: clearing only sticks once the line leaves that level
    assign line_match = ~(line_sync ^ line_level_select_reg);
    assign active_lines = line_event_flags_reg & line_interrupt_enable_reg;
    assign any_active = |active_lines;

    assign wr_idx = reg_index(awaddr_reg);
    assign do_write = aw_hold_reg && w_hold_reg;
    assign lane0 = wstrb_reg[0];
    assign wr_flags = do_write && lane0 && (wr_idx == kli_pkg::KLI_IDX_FLAGS);
    assign wr_clear = do_write && lane0 && (wr_idx == kli_pkg::KLI_IDX_IRQ_CLEAR);
    // writing one leaves a flag alone, writing zero clears it
    assign flag_keep = wr_flags ? wdata_reg[LN-1:0] : kli_pkg::KLI_LINE_ONES;
    assign line_event_flags_next = (line_event_flags_reg & flag_keep) | line_match;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            line_event_flags_reg <= kli_pkg::KLI_LINE_RESET;
        end else begin
            line_event_flags_reg <= line_event_flags_next;
        end
    end

    // ***********************************************************
    // configuration registers
    // ***********************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            line_level_select_reg <= kli_pkg::KLI_LINE_RESET;
            line_interrupt_enable_reg <= kli_pkg::KLI_LINE_RESET;
            keypad_global_enable_reg <= 1'b0;
            irq_enable_reg <= kli_pkg::KLI_IRQ_RESET;
        end else if (do_write && lane0) begin
            if (wr_idx == kli_pkg::KLI_IDX_LEVEL) begin
                line_level_select_reg <= wdata_reg[LN-1:0];
            end
            if (wr_idx == kli_pkg::KLI_IDX_ENABLE) begin
                line_interrupt_enable_reg <= wdata_reg[LN-1:0];
            end
            if (wr_idx == kli_pkg::KLI_IDX_GLOBAL) begin
                keypad_global_enable_reg <= wdata_reg[kli_pkg::KLI_GLOBAL_BIT];
            end
            if (wr_idx == kli_pkg::KLI_IDX_IRQ_ENABLE) begin
                irq_enable_reg <= wdata_reg[IW-1:0];
            end
        end
    end

    // ***********************************************************
    // keyboard request and wake
    // ***********************************************************
    // wake ignores the global enable so a masked keypad can still end power-down
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            key_req_reg <= 1'b0;
            wake_req_reg <= 1'b0;
        end else begin
            key_req_reg <= any_active && keypad_global_enable_reg;
            wake_req_reg <= any_active;
        end
    end

    assign key_req = key_req_reg;
    assign wake_req = wake_req_reg;

    // ***********************************************************
    // sticky interrupt status
    // ***********************************************************
    assign irq_events[kli_pkg::KLI_IRQ_FLAG_SET] = |(line_event_flags_next & ~line_event_flags_reg);
    assign irq_events[kli_pkg::KLI_IRQ_REQ_RISE] = any_active && keypad_global_enable_reg
                                                   && !key_req_reg;
    // a new event in the clear cycle survives
    assign irq_status_next = (wr_clear ? (irq_status_reg & ~wdata_reg[IW-1:0]) : irq_status_reg)
                             | irq_events;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_status_reg <= kli_pkg::KLI_IRQ_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    assign irq = |(irq_status_reg & irq_enable_reg);

    // ***********************************************************
    // axi4-lite write channel
    // ***********************************************************
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            w_hold_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= kli_pkg::KLI_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= idx_mapped(wr_idx) ? kli_pkg::KLI_RESP_OKAY : kli_pkg::KLI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ***********************************************************
    // axi4-lite read channel
    // ***********************************************************
    assign s_axi_arready = !rvalid_reg;
    assign rd_idx = reg_index(s_axi_araddr);

    always_comb begin
        rd_value = '0;
        unique case (rd_idx)
            kli_pkg::KLI_IDX_LEVEL: rd_value[LN-1:0] = line_level_select_reg;
            kli_pkg::KLI_IDX_ENABLE: rd_value[LN-1:0] = line_interrupt_enable_reg;
            kli_pkg::KLI_IDX_FLAGS: rd_value[LN-1:0] = line_event_flags_reg;
            kli_pkg::KLI_IDX_GLOBAL: rd_value[kli_pkg::KLI_GLOBAL_BIT] = keypad_global_enable_reg;
            kli_pkg::KLI_IDX_IRQ_STATUS: rd_value[IW-1:0] = irq_status_reg;
            kli_pkg::KLI_IDX_IRQ_ENABLE: rd_value[IW-1:0] = irq_enable_reg;
            default: rd_value = '0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= kli_pkg::KLI_RESP_OKAY;
            rdata_reg <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            rresp_reg <= idx_mapped(rd_idx) ? kli_pkg::KLI_RESP_OKAY : kli_pkg::KLI_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // ***********************************************************
    // checks
    // ***********************************************************
    chk_flag_follows_level: assert property (@(posedge clk_sys) disable iff (rst)
        1 |=> ((line_event_flags_reg & $past(line_match)) == $past(line_match)))
        else $error("matching line did not set its flag");

    chk_request_needs_enable: assert property (@(posedge clk_sys) disable iff (rst)
        !(|(line_event_flags_reg & line_interrupt_enable_reg)) |=> !key_req_reg)
        else $error("request without enabled flag");

    chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        !wr_flags |=> ((line_event_flags_reg & $past(line_event_flags_reg))
                       == $past(line_event_flags_reg)))
        else $error("flag dropped without software write");

    chk_disabled_silent: assert property (@(posedge clk_sys) disable iff (rst)
        (line_interrupt_enable_reg == kli_pkg::KLI_LINE_RESET) |=> !wake_req_reg && !key_req_reg)
        else $error("disabled lines raised a request");

    chk_level_polarity: assert property (@(posedge clk_sys) disable iff (rst)
        (line_level_select_reg[0] && !line_sync[0] && !line_event_flags_reg[0])
        |=> !line_event_flags_reg[0])
        else $error("high select flagged a low line");

    chk_reset_clears: assert property (@(posedge clk_sys)
        rst |=> (line_event_flags_reg == kli_pkg::KLI_LINE_RESET)
                && (line_interrupt_enable_reg == kli_pkg::KLI_LINE_RESET)
                && (line_level_select_reg == kli_pkg::KLI_LINE_RESET))
        else $error("registers not zero after reset");

    chk_request_merged: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(key_req_reg) |-> $past(any_active))
        else $error("request without any active line");

    chk_global_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (any_active && keypad_global_enable_reg) |=> key_req_reg)
        else $error("globally enabled request missing");

    chk_wake_raise: assert property (@(posedge clk_sys) disable iff (rst)
        any_active |=> wake_req_reg)
        else $error("wake request missing");

    chk_set_beats_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_flags && !wdata_reg[0] && line_match[0]) |=> line_event_flags_reg[0])
        else $error("clear won over flag set");

    chk_write_answer: assert property (@(posedge clk_sys) disable iff (rst)
        do_write |=> s_axi_bvalid)
        else $error("write response missing");

    cov_flag_set: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(line_event_flags_reg[0]));
    cov_key_request: cover property (@(posedge clk_sys) disable iff (rst) $rose(key_req_reg));
    cov_flag_clear: cover property (@(posedge clk_sys) disable iff (rst)
        wr_flags ##1 $fell(line_event_flags_reg[0]));
    cov_irq_out: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
endmodule : kli_keypad_top

// [rtl/kli_line_sync.sv]
// two-stage synchroniser for the eight port lines
`timescale 1ns/1ns
module kli_line_sync (
    input wire logic clk_sys,
    input wire logic rst,
    kli_sync_if.sync lines
);
    // ***********************************************************
    // one two-flop chain per line
    // ***********************************************************
    // first stage is read only by the second stage to keep metastability contained
    genvar gi;
    generate
        for (gi = 0; gi < kli_pkg::KLI_LINES; gi++) begin : g_line
            logic meta_reg;
            logic stable_reg;
            always_ff @(posedge clk_sys) begin
                // reset to the level the reset level select ignores, so reset fakes no key
                if (rst) begin
                    meta_reg <= ~kli_pkg::KLI_LINE_RESET[gi];
                    stable_reg <= ~kli_pkg::KLI_LINE_RESET[gi];
                end else begin
                    meta_reg <= lines.raw[gi];
                    stable_reg <= meta_reg;
                end
            end
            assign lines.synced[gi] = stable_reg;
        end
    endgenerate
endmodule : kli_line_sync

// [tb/kli_keypad_model.sv]
// keypad matrix model that drives the eight port lines
`timescale 1ns/1ns
module kli_keypad_model (
    input wire logic clk_sys,
    input wire logic [7:0] pressed,
    output logic [7:0] lines
);
    // ***********************************************************
    // matrix lines
    // ***********************************************************
    // pull-ups hold a free line high; a closed key grounds it one clock later
    always_ff @(posedge clk_sys) begin
        lines <= ~pressed;
    end
endmodule : kli_keypad_model

// [tb/tb.sv]
// self-checking bench for the keypad level interrupt unit
`timescale 1ns/1ns
module tb;
    localparam logic [11:0] A_LVL = {kli_pkg::KLI_IDX_LEVEL, 2'h0};
    localparam logic [11:0] A_EN = {kli_pkg::KLI_IDX_ENABLE, 2'h0};
    localparam logic [11:0] A_FLG = {kli_pkg::KLI_IDX_FLAGS, 2'h0};
    localparam logic [11:0] A_GLB = {kli_pkg::KLI_IDX_GLOBAL, 2'h0};
    localparam logic [11:0] A_IS = {kli_pkg::KLI_IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] A_IC = {kli_pkg::KLI_IDX_IRQ_CLEAR, 2'h0};
    localparam logic [11:0] A_IE = {kli_pkg::KLI_IDX_IRQ_ENABLE, 2'h0};
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic [7:0] pressed = 8'h00;
    logic [7:0] port_lines;
    logic key_req, wake_req, irq;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, got;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] lfsr_state = 32'h06E8F099;
    int mismatches = 0;
    int check_count = 0;

    always #10 clk_sys = ~clk_sys;

    kli_keypad_model kli_keypad_model_i (.clk_sys(clk_sys), .pressed(pressed),
        .lines(port_lines));
    kli_keypad_top kli_keypad_top_i (.clk_sys(clk_sys), .rst(rst), .port_lines(port_lines),
        .key_req(key_req), .wake_req(wake_req), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ***********************************************************
    // expectation helpers
    // ***********************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'h0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr_next

    // a line matches when its level (inverse of the key) equals the selected level
    function automatic logic [7:0] match_of(input logic [7:0] lvl, input logic [7:0] keys);
        return ~(~keys ^ lvl);
    endfunction : match_of

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD at %0t got %h expected %h", $time, g, e);
        end
    endtask : check

    // ***********************************************************
    // axi4-lite master
    // ***********************************************************
    // handshakes are judged at the falling edge, where inputs and registers are settled
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
        output logic [1:0] resp);
        int n = 0;
        logic aw_go, w_go, b_go;
        b_go = 1'h0;
        resp = 2'h3;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!b_go && n < 50) begin
            @(negedge clk_sys);
            aw_go = awvalid & awready;
            w_go = wvalid & wready;
            b_go = bready & bvalid;
            if (b_go) resp = bresp;
            @(posedge clk_sys);
            if (aw_go) awvalid <= 1'h0;
            if (w_go) wvalid <= 1'h0;
            if (b_go) bready <= 1'h0;
            n++;
        end
        if (!b_go) check(32'h0, 32'h1);
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
        output logic [1:0] resp);
        int n = 0;
        logic ar_go, r_go;
        r_go = 1'h0;
        resp = 2'h3;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!r_go && n < 50) begin
            @(negedge clk_sys);
            ar_go = arvalid & arready;
            r_go = rready & rvalid;
            if (r_go) d = rdata;
            if (r_go) resp = rresp;
            @(posedge clk_sys);
            if (ar_go) arvalid <= 1'h0;
            if (r_go) rready <= 1'h0;
            n++;
        end
        if (!r_go) check(32'h0, 32'h1);
    endtask : axi_read

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check({30'h0, r}, {30'h0, kli_pkg::KLI_RESP_OKAY});
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [1:0] r;
        axi_read(a, got, r);
        check(got, e);
        check({30'h0, r}, {30'h0, kli_pkg::KLI_RESP_OKAY});
    endtask : rdc

    // ***********************************************************
    // scenarios
    // ***********************************************************
    initial begin
        logic [7:0] lvl, keys, en, m;
        logic glb;
        logic [1:0] ien, st, r;
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        // free lines sit high, so low detection after reset sets nothing
        @(negedge clk_sys);
        check(32'({key_req, wake_req, irq}), 32'h0);
        rdc(A_LVL, 32'h0);
        rdc(A_EN, 32'h0);
        rdc(A_FLG, 32'h0);
        rdc(A_IC, 32'h0);
        axi_read(12'h004, got, r);
        check({got[29:0], r}, {30'h0, kli_pkg::KLI_RESP_SLVERR});
        axi_write(12'h3FC, 32'hFF, r);
        check({30'h0, r}, {30'h0, kli_pkg::KLI_RESP_SLVERR});
        wr(A_FLG, 32'hFF);
        rdc(A_FLG, 32'h0);
        for (int i = 0; i < 16; i++) begin
            lfsr_state = lfsr_next(lfsr_state);
            {ien, glb, en, keys, lvl} = lfsr_state[26:0];
            // corners: every line hit with nothing enabled; one line gated globally off
            if (i == 0) {ien, glb, en, keys, lvl} = {2'h3, 1'h1, 8'h00, 8'hFF, 8'h00};
            if (i == 1) {ien, glb, en, keys, lvl} = {2'h3, 1'h0, 8'h80, 8'h00, 8'hFF};
            wr(A_LVL, {24'h0, lvl});
            pressed <= lvl;
            repeat (6) @(posedge clk_sys);
            wr(A_FLG, 32'h0);
            wr(A_IC, 32'h3);
            rdc(A_IS, 32'h0);
            wr(A_EN, {24'h0, en});
            wr(A_GLB, {31'h0, glb});
            wr(A_IE, {30'h0, ien});
            rdc(A_FLG, 32'h0);
            m = match_of(lvl, keys);
            pressed <= keys;
            repeat (8) @(posedge clk_sys);
            rdc(A_FLG, {24'h0, m});
            @(negedge clk_sys);
            check(32'(wake_req), 32'(|(m & en)));
            check(32'(key_req), 32'(glb & |(m & en)));
            st = {glb & |(m & en), |m};
            rdc(A_IS, {30'h0, st});
            @(negedge clk_sys);
            check(32'(irq), 32'(|(st & ien)));
            @(posedge clk_sys);
            pressed <= lvl;
            repeat (8) @(posedge clk_sys);
            rdc(A_FLG, {24'h0, m});
        end
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        test_done();
    end
endmodule : tb
